// *** verilog/fbx_pkg.sv ***
// Package for the host-side controller of a parallel pair of ripple-through FIFOs
// Contract
// - In paced mode the host pulses shift-in or shift-out only once the matching flag has become valid.
// - In burst mode the host pulses without looking at the flags, paced only by its own pulse widths; the code also holds both strobes on the fill count.
// - During a burst the host never shifts in more words than the free storage holds.
// - Width grows by paralleling devices and merging their flags through one gate, adding one gate delay.
// - With shift-in held high while empty, the host builds a proper combined ready instead of a plain AND; the host only pulses shift-in and uses a plain AND.
package fbx_pkg;
  localparam int UNIT_W = 4;
  localparam int UNITS = 2;
  localparam int WORD_W = UNIT_W * UNITS;
  localparam int DEPTH = 16;
  localparam int CLK_HZ = 20_000_000;
  localparam int BURST_HZ = 35_000_000;
  // Half a burst period, at least one cycle
  localparam int BURST_HALF_CYC = (CLK_HZ + 2 * BURST_HZ - 1) / (2 * BURST_HZ) < 1 ? 1 :
    (CLK_HZ + 2 * BURST_HZ - 1) / (2 * BURST_HZ);
  localparam int CNT_W = 5;
  typedef struct packed {
    logic [WORD_W-1:0] data;
  } fbx_word_t;
  typedef enum logic {FBX_PACED, FBX_BURST} fbx_mode_t;
endpackage

// *** verilog/fbx_host.sv ***
// Host controller writing to and reading from two paralleled ripple-through FIFOs
`timescale 1ns/10ps
`default_nettype none
module fbx_host #(
  parameter int DEPTH = fbx_pkg::DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic burst_mode,
  input wire logic wr_valid,
  input wire fbx_pkg::fbx_word_t wr_word,
  output logic wr_ready,
  output logic rd_valid,
  output fbx_pkg::fbx_word_t rd_word,
  input wire logic rd_ready,
  output logic shift_in,
  output fbx_pkg::fbx_word_t word_inputs,
  input wire logic [fbx_pkg::UNITS-1:0] in_ready_pins,
  output logic shift_out,
  input wire fbx_pkg::fbx_word_t word_outputs,
  input wire logic [fbx_pkg::UNITS-1:0] output_valid_flag
);
  typedef enum logic [1:0] {FBX_W_IDLE, FBX_W_SETUP, FBX_W_HIGH, FBX_W_LOW} fbx_wst_t;
  typedef enum logic [1:0] {FBX_R_IDLE, FBX_R_HIGH, FBX_R_LOW} fbx_rst_t;
  localparam int HC = fbx_pkg::BURST_HALF_CYC;
  // Fill counter holds DEPTH itself, so one full part can be counted
  localparam int FW = $clog2(DEPTH + 1);

  // Group flag: every unit of the width group must agree
  function automatic logic fbx_all(input logic [fbx_pkg::UNITS-1:0] flags);
    return &flags;
  endfunction

  // Gating term of the current mode for starting a strobe
  function automatic logic fbx_go(input logic mode, input logic flag_ok, input logic count_ok);
    if (mode == fbx_pkg::FBX_BURST) begin
      return count_ok;
    end
    return flag_ok;
  endfunction

  logic [fbx_pkg::UNITS-1:0] irdy_s1, irdy_s2, ovld_s1, ovld_s2;
  fbx_pkg::fbx_word_t q_s1, q_s2;
  fbx_wst_t wst, next_wst;
  fbx_rst_t rst_st, next_rst_st;
  logic [3:0] wtim, next_wtim, rtim, next_rtim;
  logic [FW-1:0] fill, next_fill;
  logic next_shift_in, next_shift_out;
  fbx_pkg::fbx_word_t next_word_inputs;
  fbx_pkg::fbx_word_t buf0, buf1, next_buf0, next_buf1;
  logic [1:0] bcnt, next_bcnt;
  logic group_ready, group_valid, take_w, push_r, pop_r;

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    irdy_s1 <= in_ready_pins;
    irdy_s2 <= irdy_s1;
    ovld_s1 <= output_valid_flag;
    ovld_s2 <= ovld_s1;
    // Data is sampled only once settled, so two plain stages suffice
    q_s1 <= word_outputs;
    q_s2 <= q_s1;
  end

  // Combined flags: all members must agree, sampled only after sync
  // Synced flags lag the pins by two cycles after every strobe
  assign group_ready = fbx_all(irdy_s2);
  assign group_valid = fbx_all(ovld_s2);

  // In burst mode the fill count alone keeps writes inside the storage
  assign take_w = (wst == FBX_W_IDLE) && wr_valid && fbx_go(burst_mode, group_ready, fill < FW'(DEPTH));
  // Output word is taken at the end of the high phase of the read strobe
  assign push_r = (rst_st == FBX_R_HIGH) && (rtim == 4'd0);
  assign pop_r = rd_ready && (bcnt != 2'd0);

  // Write strobe sequencing
  always_comb begin
    next_wst = wst;
    next_wtim = wtim;
    next_shift_in = shift_in;
    next_word_inputs = word_inputs;
    unique case (wst)
      FBX_W_IDLE: begin
        if (take_w) begin
          next_word_inputs = wr_word;
          next_wst = FBX_W_SETUP;
        end
      end
      // Word stands a full cycle on the pins before the rising strobe
      FBX_W_SETUP: begin
        next_wst = FBX_W_HIGH;
        next_wtim = 4'(HC);
        next_shift_in = 1'b1;
      end
      FBX_W_HIGH: begin
        if (wtim != 4'd0) begin
          next_wtim = wtim - 4'd1;
        end else begin
          next_shift_in = 1'b0;
          next_wst = FBX_W_LOW;
          next_wtim = 4'(HC);
        end
      end
      FBX_W_LOW: begin
        if (wtim != 4'd0) begin
          next_wtim = wtim - 4'd1;
        end else begin
          next_wst = FBX_W_IDLE;
        end
      end
    endcase
  end

  // Read strobe sequencing; stalls when the two-entry buffer is full
  always_comb begin
    next_rst_st = rst_st;
    next_rtim = rtim;
    next_shift_out = shift_out;
    unique case (rst_st)
      FBX_R_IDLE: begin
        // Burst reads wait for an idle writer, so every counted word has rippled to the outputs
        if ((bcnt < 2'd2 || pop_r) &&
            fbx_go(burst_mode, group_valid, (fill != '0) && (wst == FBX_W_IDLE))) begin
          next_rst_st = FBX_R_HIGH;
          next_rtim = 4'(HC);
          next_shift_out = 1'b1;
        end
      end
      FBX_R_HIGH: begin
        if (rtim != 4'd0) begin
          next_rtim = rtim - 4'd1;
        end else begin
          next_shift_out = 1'b0;
          next_rst_st = FBX_R_LOW;
          // Low phase covers the pop, the ripple and both synchroniser stages
          next_rtim = 4'(HC + 2);
        end
      end
      FBX_R_LOW: begin
        if (rtim != 4'd0) begin
          next_rtim = rtim - 4'd1;
        end else begin
          next_rst_st = FBX_R_IDLE;
        end
      end
    endcase
  end

  // Fill count of the device and the two-entry output buffer
  always_comb begin
    next_fill = fill;
    if (take_w && !push_r) begin
      next_fill = fill + FW'(1);
    end else if (push_r && !take_w) begin
      next_fill = fill - FW'(1);
    end
    next_buf0 = buf0;
    next_buf1 = buf1;
    next_bcnt = bcnt;
    if (pop_r) begin
      next_buf0 = buf1;
      next_bcnt = bcnt - 2'd1;
    end
    if (push_r) begin
      if (next_bcnt == 2'd0) begin
        next_buf0 = q_s2;
      end else begin
        next_buf1 = q_s2;
      end
      next_bcnt = next_bcnt + 2'd1;
    end
  end

  // Write group
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wst <= FBX_W_IDLE;
      wtim <= 4'h0;
      shift_in <= 1'b0;
      word_inputs <= '0;
      wr_ready <= 1'b0;
    end else begin
      wst <= next_wst;
      wtim <= next_wtim;
      shift_in <= next_shift_in;
      word_inputs <= next_word_inputs;
      wr_ready <= (next_wst == FBX_W_IDLE);
    end
  end

  // Read group
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_st <= FBX_R_IDLE;
      rtim <= 4'h0;
      shift_out <= 1'b0;
    end else begin
      rst_st <= next_rst_st;
      rtim <= next_rtim;
      shift_out <= next_shift_out;
    end
  end

  // Fill count and output buffer group
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fill <= '0;
      buf0 <= '0;
      buf1 <= '0;
      bcnt <= 2'd0;
      rd_valid <= 1'b0;
      rd_word <= '0;
    end else begin
      fill <= next_fill;
      buf0 <= next_buf0;
      buf1 <= next_buf1;
      bcnt <= next_bcnt;
      rd_valid <= (next_bcnt != 2'd0);
      rd_word <= next_buf0;
    end
  end
endmodule
`default_nettype wire

// *** tb/fbx_fifo_model.sv ***
// Two paralleled ripple-through FIFOs on common strobes
`timescale 1ns/10ps
`default_nettype none
module fbx_fifo_model #(parameter int DEPTH = 16) (
  input wire logic ref_clk,
  input wire logic shift_in,
  input wire fbx_pkg::fbx_word_t word_inputs,
  input wire logic shift_out,
  output logic [1:0] in_ready_pins,
  output logic [1:0] output_valid_flag,
  output fbx_pkg::fbx_word_t word_outputs,
  output logic overflow
);
  logic [7:0] m[$];
  initial begin
    overflow = 0;
    in_ready_pins = 0;
    output_valid_flag = 0;
    word_outputs = 0;
  end
  always @(posedge shift_in) if (m.size() < DEPTH) m.push_back(word_inputs); else overflow = 1;
  always @(negedge shift_out) if (m.size() != 0) void'(m.pop_front());
  // Second unit lags by a cycle, as ripple times spread
  always @(posedge ref_clk) begin
    in_ready_pins <= {in_ready_pins[0], m.size() < DEPTH && !shift_in};
    output_valid_flag <= {output_valid_flag[0], m.size() != 0 && !shift_out};
    word_outputs <= m.size() != 0 ? m[0] : ~word_outputs;
  end
endmodule
`default_nettype wire

// *** tb/fbx_host_sva.sv ***
// Checker for the host strobes and handshakes
`timescale 1ns/10ps
`default_nettype none
module fbx_host_sva (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic burst_mode,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire fbx_pkg::fbx_word_t rd_word,
  input wire logic rd_ready,
  input wire logic shift_in,
  input wire fbx_pkg::fbx_word_t word_inputs,
  input wire logic [fbx_pkg::UNITS-1:0] in_ready_pins,
  input wire logic shift_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_si_w; $rose(shift_in) |-> ##1 shift_in ##1 !shift_in[*3]; endproperty
  a_si_w: assert property (p_si_w) else $error("shift_in width");
  property p_so_w; $rose(shift_out) |-> ##1 shift_out ##1 !shift_out[*4]; endproperty
  a_so_w: assert property (p_so_w) else $error("shift_out width");
  property p_paced; $rose(shift_in) && !burst_mode |-> $past(&in_ready_pins, 4); endproperty
  a_paced: assert property (p_paced) else $error("shift_in without ready");
  property p_busy; $rose(shift_in) |-> !wr_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while loading");
  property p_setup; $rose(shift_in) |-> $stable(word_inputs); endproperty
  a_setup: assert property (p_setup) else $error("word not set up");
  property p_hold; shift_in && $past(shift_in) |-> $stable(word_inputs); endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_back; $fell(shift_in) |-> ##2 wr_ready; endproperty
  a_back: assert property (p_back) else $error("ready late");
  property p_rd; $fell(shift_out) |-> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("no read word");
  property p_stall; rd_valid && !rd_ready |=> rd_valid && $stable(rd_word); endproperty
  a_stall: assert property (p_stall) else $error("word lost");
  cover property ($rose(shift_in) && burst_mode);
  cover property ($rose(shift_in) && !burst_mode);
  cover property (rd_valid && !rd_ready);
endmodule
bind fbx_host fbx_host_sva u_fbx_host_sva(.ref_clk(ref_clk), .srst(srst), .burst_mode(burst_mode),
  .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_word(rd_word), .rd_ready(rd_ready), .shift_in(shift_in),
  .word_inputs(word_inputs), .in_ready_pins(in_ready_pins), .shift_out(shift_out));
`default_nettype wire

// *** tb/fbx_host_test.sv ***
// Self-checking bench for the paralleled FIFO host
`timescale 1ns/10ps
`default_nettype none
module fbx_host_test;
  logic ref_clk, srst, burst_mode, wr_valid, wr_ready, rd_valid, rd_ready, shift_in, shift_out, overflow;
  fbx_pkg::fbx_word_t wr_word, rd_word, word_inputs, word_outputs;
  logic [1:0] in_ready_pins, output_valid_flag;
  int miscompares, total_checks;
  fbx_host u_fbx_host(.ref_clk(ref_clk), .srst(srst), .burst_mode(burst_mode), .wr_valid(wr_valid),
    .wr_word(wr_word), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_word(rd_word), .rd_ready(rd_ready),
    .shift_in(shift_in), .word_inputs(word_inputs), .in_ready_pins(in_ready_pins), .shift_out(shift_out),
    .word_outputs(word_outputs), .output_valid_flag(output_valid_flag));
  fbx_fifo_model u_fbx_fifo_model(.ref_clk(ref_clk), .shift_in(shift_in), .word_inputs(word_inputs),
    .shift_out(shift_out), .in_ready_pins(in_ready_pins), .output_valid_flag(output_valid_flag),
    .word_outputs(word_outputs), .overflow(overflow));
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] a, input logic [7:0] e);
    total_checks++;
    if (a !== e) begin
      miscompares++;
      $display("MISMATCH %0t %h %h", $time, a, e);
    end
  endtask
  task cyc;
    @(posedge ref_clk);
    #1;
  endtask
  task tmo(input int i);
    if (i >= 300) begin
      miscompares++;
      complete_run;
    end
  endtask
  task wr(input logic [7:0] w);
    int i;
    wr_word = w;
    wr_valid = 1;
    for (i = 0; i < 300 && !shift_in; i++) cyc;
    wr_valid = 0;
    tmo(i);
    chk(word_inputs, w);
    for (i = 0; i < 9 && shift_in; i++) cyc;
  endtask
  task rd(input logic [7:0] e);
    int i;
    logic [7:0] g;
    rd_ready = 1;
    for (i = 0; i < 300 && !rd_valid; i++) cyc;
    g = rd_word;
    cyc;
    tmo(i);
    chk(g, e);
  endtask
  task t_paced;
    int k;
    burst_mode = 0;
    for (k = 0; k < 3; k++) wr(8'h3c ^ 8'(k));
    for (k = 0; k < 3; k++) rd(8'h3c ^ 8'(k));
    rd_ready = 0;
  endtask
  task t_burst;
    int k;
    burst_mode = 1;
    for (k = 0; k < 18; k++) wr(8'ha5 ^ 8'(k));
    wr_word = 8'h00;
    wr_valid = 1;
    repeat (40) cyc;
    chk({7'h00, shift_in}, 8'h00);
    wr_valid = 0;
    chk({7'h00, overflow}, 8'h00);
    chk(8'(u_fbx_fifo_model.m.size()), 8'h10);
    for (k = 0; k < 18; k++) rd(8'ha5 ^ 8'(k));
    rd_ready = 0;
  endtask
  initial begin
    srst = 1;
    burst_mode = 0;
    wr_valid = 0;
    wr_word = 0;
    rd_ready = 0;
    miscompares = 0;
    total_checks = 0;
    repeat (4) @(posedge ref_clk);
    #1 srst = 0;
    t_paced;
    t_burst;
    complete_run;
  end
endmodule
`default_nettype wire
